// [design/cagen_agu.sv]
// Module: combinational operand address generator for every addressing mode
`timescale 1ns/1ps
module cagen_agu (
  cagen_agu_if.agu bus
);
  // Sign-extended branch offset
  wire [15:0] rel_ext = {{8{bus.operand[7]}}, bus.operand[7:0]};
  // Zero-extended short offset
  wire [15:0] short_ext = {8'h00, bus.operand[7:0]};
  // Candidate sums, all wrap within 64 Kbytes
  wire [15:0] rel_sum = 16'(bus.pc + rel_ext);
  wire [15:0] ptr_short = 16'(bus.pointer + short_ext);
  wire [15:0] ptr_long = 16'(bus.pointer + bus.operand);
  wire [15:0] sp_short = 16'(bus.stack_pointer + short_ext);
  wire [15:0] sp_long = 16'(bus.stack_pointer + bus.operand);

  // Pointer increment wraps at the top of memory
  assign bus.pointer_inc = 16'(bus.pointer + cagen_pkg::POSTINC_STEP);
  assign bus.postinc = (bus.mode == cagen_pkg::CAGEN_POINTER_POSTINC_MODE) ||
                       (bus.mode == cagen_pkg::CAGEN_POINTER_SHORT_OFFSET_POSTINC_MODE);
  // No memory read for register, inline or branch forms
  assign bus.mem_read = !((bus.mode == cagen_pkg::CAGEN_REGISTER_ONLY_MODE) ||
                          (bus.mode == cagen_pkg::CAGEN_RELATIVE_MODE) ||
                          (bus.mode == cagen_pkg::CAGEN_INLINE_OPERAND_MODE));

  // Address selection per mode
  always_comb begin
    case (bus.mode)
      cagen_pkg::CAGEN_RELATIVE_MODE: bus.addr = bus.branch_taken ? rel_sum : bus.pc;
      cagen_pkg::CAGEN_PAGE_ZERO_MODE: bus.addr = {cagen_pkg::PAGE_ZERO_HI, bus.operand[7:0]};
      cagen_pkg::CAGEN_FULL_ADDRESS_MODE: bus.addr = bus.operand;
      cagen_pkg::CAGEN_POINTER_PLAIN_MODE: bus.addr = bus.pointer;
      cagen_pkg::CAGEN_POINTER_POSTINC_MODE: bus.addr = bus.pointer;
      cagen_pkg::CAGEN_POINTER_SHORT_OFFSET_MODE: bus.addr = ptr_short;
      cagen_pkg::CAGEN_POINTER_SHORT_OFFSET_POSTINC_MODE: bus.addr = ptr_short;
      cagen_pkg::CAGEN_POINTER_LONG_OFFSET_MODE: bus.addr = ptr_long;
      cagen_pkg::CAGEN_STACK_SHORT_OFFSET_MODE: bus.addr = sp_short;
      cagen_pkg::CAGEN_STACK_LONG_OFFSET_MODE: bus.addr = sp_long;
      // Register-only and inline forms: no operand address
      default: bus.addr = bus.pc;
    endcase
  end
endmodule

// [design/cagen_agu_if.sv]
// Interface: operand address request and result between sequencer and adder
`timescale 1ns/1ps
interface cagen_agu_if;
  cagen_pkg::cagen_mode_e mode; // Addressing mode
  logic [15:0] operand; // Instruction operand bytes, high byte first
  logic [15:0] pointer; // Pointer pair upper:lower
  logic [15:0] stack_pointer; // Stack pointer
  logic [15:0] pc; // Program counter after operand
  logic branch_taken; // Branch condition holds
  logic [15:0] addr; // Formed address
  logic mem_read; // Operand needs a memory read
  logic postinc; // Pointer increments after fetch
  logic [15:0] pointer_inc; // Pointer plus one
  modport seq (output mode, operand, pointer, stack_pointer, pc, branch_taken,
               input addr, mem_read, postinc, pointer_inc);
  modport agu (input mode, operand, pointer, stack_pointer, pc, branch_taken,
               output addr, mem_read, postinc, pointer_inc);
endinterface

// [design/cagen_pkg.sv]
// Package: constants and types for the address generator and exception sequencer
package cagen_pkg;
  // Reset vector locations
  localparam logic [15:0] RESET_VEC_HI = 16'hFFFE;
  localparam logic [15:0] RESET_VEC_LO = 16'hFFFF;
  // Reset fetch sequence length in cycles
  localparam logic [2:0] RESET_SEQ_CYCLES = 3'h6;
  // Queue fill bytes after a vector fetch
  localparam logic [1:0] QUEUE_FILL_BYTES = 2'h3;
  // Interrupt mask position in the flags register
  localparam int IMASK_BIT = 3;
  // Flags register reset value: mask set, bits 6 and 5 fixed high
  localparam logic [7:0] FLAGS_RESET = 8'h68;
  // Upper byte used in page-zero mode
  localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
  // Pointer post-increment step
  localparam logic [15:0] POSTINC_STEP = 16'h0001;
  // Stack pointer reset value
  localparam logic [15:0] SP_RESET = 16'h00FF;

  // Addressing modes
  typedef enum logic [3:0] {
    CAGEN_REGISTER_ONLY_MODE          = 4'h0,
    CAGEN_RELATIVE_MODE               = 4'h1,
    CAGEN_INLINE_OPERAND_MODE         = 4'h2,
    CAGEN_PAGE_ZERO_MODE              = 4'h3,
    CAGEN_FULL_ADDRESS_MODE           = 4'h4,
    CAGEN_POINTER_PLAIN_MODE          = 4'h5,
    CAGEN_POINTER_POSTINC_MODE        = 4'h6,
    CAGEN_POINTER_SHORT_OFFSET_MODE   = 4'h7,
    CAGEN_POINTER_SHORT_OFFSET_POSTINC_MODE = 4'h8,
    CAGEN_POINTER_LONG_OFFSET_MODE    = 4'h9,
    CAGEN_STACK_SHORT_OFFSET_MODE     = 4'hA,
    CAGEN_STACK_LONG_OFFSET_MODE      = 4'hB
  } cagen_mode_e;

  // Sequencer states, Gray coded along reset, run, stacking and vector path
  typedef enum logic [3:0] {
    CAGEN_ST_RESET  = 4'h0,
    CAGEN_ST_RVEC   = 4'h1,
    CAGEN_ST_RUN    = 4'h3,
    CAGEN_ST_PUSH   = 4'h2,
    CAGEN_ST_VECHI  = 4'h6,
    CAGEN_ST_VECLO  = 4'h7,
    CAGEN_ST_FREE   = 4'h5,
    CAGEN_ST_FILL   = 4'h4,
    CAGEN_ST_IDLE   = 4'hC,
    CAGEN_ST_HALT   = 4'hD,
    CAGEN_ST_DEBUG  = 4'hF
  } cagen_state_e;
endpackage

// [design/cagen_top.sv]
// Module: address generation and reset, interrupt, idle, halt and debug sequencing
//
// Functional notes
// - register-only mode reads no memory operand
// - branch adds sign-extended offset to program counter
// - inline 16-bit operand high byte first
// - page-zero address has upper byte zero
// - full address from two bytes, high first
// - plain pointer pair is the address
// - post-increment pointer modes add one after fetch
// - pointer plus unsigned 8-bit offset
// - pointer plus 16-bit offset
// - stack pointer plus 8- or 16-bit offset
// - reset abandons activity immediately
// - after reset, 6-cycle vector fetch sequence
// - interrupts taken only at instruction boundary
// - vector from highest pending priority at start
// - push pc low, pc high, pointer low, accumulator, flags
// - vector high, vector low, free cycle, three fills
// - upper pointer byte is never stacked
// - soft trap ignores the interrupt mask
// - idle clears mask, gates clocks, wakes on event
// - debug-halt command wakes idle, or halt with debug enable set, into debug
// - debug enable keeps oscillator running in halt
// - interrupt mask is flags bit 3
`timescale 1ns/1ps
module cagen_top #(
  parameter int NUM_IRQ = 8 // Number of hardware interrupt sources
) (
  input wire logic i_clock,
  input wire logic i_reset, // Async reset: power-up, watchdog or pin
  input wire logic i_reset_done, // Source determination finished and pin released
  input wire logic i_boundary, // Current instruction has completed
  input wire logic i_soft_trap_op, // Soft trap opcode decoded at boundary
  input wire logic i_idle_op, // Idle instruction decoded
  input wire logic i_halt_op, // Deep halt instruction decoded
  input wire logic i_debug_halt_cmd, // Debug-halt serial command received
  input wire logic i_debug_enable_set, // Serial command setting debug enable bit
  input wire logic i_reset_into_debug, // Reset was into active debug state
  input wire logic [NUM_IRQ-1:0] i_irq, // Pending interrupts, bit 0 highest priority
  input wire logic [NUM_IRQ*16-1:0] i_irq_vec, // Vector address per source
  input wire logic [15:0] i_soft_trap_vec, // Vector address for the soft trap
  input wire logic [3:0] i_mode, // Addressing mode of current access
  input wire logic [15:0] i_operand, // Instruction operand bytes
  input wire logic [15:0] i_pointer, // Pointer pair
  input wire logic [15:0] i_pc, // Program counter
  input wire logic [7:0] i_accumulator, // Accumulator
  input wire logic [15:0] i_stack_pointer, // Stack pointer
  input wire logic i_branch_taken, // Branch condition holds
  input wire logic i_operand_fetch, // Operand access happens this cycle
  input wire logic [7:0] i_rdata, // Memory read data
  output logic [15:0] o_addr, // Memory address
  output logic o_rd, // Memory read strobe
  output logic o_wr, // Memory write strobe
  output logic [7:0] o_wdata, // Memory write data
  output logic [15:0] o_pointer, // Pointer pair after post-increment
  output logic o_pointer_load, // Pointer pair update pulse
  output logic [15:0] o_pc, // New fetch address
  output logic [15:0] o_stack_pointer, // Stack pointer after stacking
  output logic [7:0] o_flags, // Flags register
  output logic o_cpu_clock_en, // CPU clock gate enable
  output logic o_osc_run, // Oscillator kept running in halt
  output logic o_debug_active, // Active debug state
  output logic o_exec // Instruction execution allowed
);
  ////////////////////////////////////////////////////////////////////////////
  // Address generator
  cagen_agu_if agu_bus ();
  assign agu_bus.mode = cagen_pkg::cagen_mode_e'(i_mode);
  assign agu_bus.operand = i_operand;
  assign agu_bus.pointer = i_pointer;
  assign agu_bus.stack_pointer = i_stack_pointer;
  assign agu_bus.pc = i_pc;
  assign agu_bus.branch_taken = i_branch_taken;
  cagen_agu u_agu (
    .bus(agu_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State and registers
  cagen_pkg::cagen_state_e state_r, state_nxt; // Sequencer state
  logic [2:0] count_r; // Step counter within a state
  logic [15:0] vector_r; // Latched vector address
  logic [15:0] sp_r; // Working stack pointer
  logic [15:0] newpc_r; // Vector being assembled
  logic [7:0] flags_r; // Flags register
  logic debug_en_r; // Debug enable bit
  logic intr_take; // Boundary with serviceable event

  ////////////////////////////////////////////////////////////////////////////
  // Priority select of highest pending interrupt
  logic [15:0] irq_vector; // Chosen vector
  logic irq_any; // Any interrupt pending
  always_comb begin
    irq_vector = i_soft_trap_vec;
    irq_any = 1'b0;
    for (int k = NUM_IRQ - 1; k >= 0; k--) begin
      if (i_irq[k]) begin
        irq_vector = i_irq_vec[k*16 +: 16];
        irq_any = 1'b1;
      end
    end
  end

  // Mask gates hardware only; soft trap always taken
  wire irq_ok = irq_any && !flags_r[cagen_pkg::IMASK_BIT];
  assign intr_take = i_boundary && (irq_ok || i_soft_trap_op);
  // Hardware takes priority for vector choice
  wire [15:0] take_vector = irq_ok ? irq_vector : i_soft_trap_vec;
  // Idle wakes on any pending request even when masked
  wire wake_event = irq_any;

  ////////////////////////////////////////////////////////////////////////////
  // Stack byte for each push step, upper pointer byte never stacked
  logic [7:0] push_byte;
  always_comb begin
    case (count_r)
      3'h0: push_byte = i_pc[7:0];
      3'h1: push_byte = i_pc[15:8];
      3'h2: push_byte = i_pointer[7:0];
      3'h3: push_byte = i_accumulator;
      default: push_byte = flags_r;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cagen_pkg::CAGEN_ST_RESET: begin
        if (i_reset_done) begin
          state_nxt = cagen_pkg::CAGEN_ST_RVEC;
        end
      end
      cagen_pkg::CAGEN_ST_RVEC: begin
        if (count_r == cagen_pkg::RESET_SEQ_CYCLES - 3'h1) begin
          state_nxt = cagen_pkg::CAGEN_ST_RUN;
        end
      end
      cagen_pkg::CAGEN_ST_RUN: begin
        if (intr_take) begin
          state_nxt = cagen_pkg::CAGEN_ST_PUSH;
        end else if (i_boundary && i_idle_op) begin
          state_nxt = cagen_pkg::CAGEN_ST_IDLE;
        end else if (i_boundary && i_halt_op) begin
          state_nxt = cagen_pkg::CAGEN_ST_HALT;
        end
      end
      cagen_pkg::CAGEN_ST_PUSH: begin
        if (count_r == 3'h4) begin
          state_nxt = cagen_pkg::CAGEN_ST_VECHI;
        end
      end
      cagen_pkg::CAGEN_ST_VECHI: state_nxt = cagen_pkg::CAGEN_ST_VECLO;
      cagen_pkg::CAGEN_ST_VECLO: state_nxt = cagen_pkg::CAGEN_ST_FREE;
      cagen_pkg::CAGEN_ST_FREE: state_nxt = cagen_pkg::CAGEN_ST_FILL;
      cagen_pkg::CAGEN_ST_FILL: begin
        if (count_r == {1'b0, cagen_pkg::QUEUE_FILL_BYTES} - 3'h1) begin
          state_nxt = cagen_pkg::CAGEN_ST_RUN;
        end
      end
      cagen_pkg::CAGEN_ST_IDLE: begin
        if (i_debug_halt_cmd) begin
          state_nxt = cagen_pkg::CAGEN_ST_DEBUG;
        end else if (wake_event) begin
          state_nxt = cagen_pkg::CAGEN_ST_RUN;
        end
      end
      cagen_pkg::CAGEN_ST_HALT: begin
        if (i_debug_halt_cmd && debug_en_r) begin
          state_nxt = cagen_pkg::CAGEN_ST_DEBUG;
        end else if (wake_event) begin
          state_nxt = cagen_pkg::CAGEN_ST_RUN;
        end
      end
      cagen_pkg::CAGEN_ST_DEBUG: state_nxt = cagen_pkg::CAGEN_ST_DEBUG;
      default: state_nxt = cagen_pkg::CAGEN_ST_RESET;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer registers; async reset abandons any sequence at once
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_r <= cagen_pkg::CAGEN_ST_RESET;
      count_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      count_r <= (state_nxt == state_r) ? 3'(count_r + 3'h1) : 3'h0;
    end
  end

  // Vector latched as sequence begins
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      vector_r <= 16'h0000;
    end else if (state_r == cagen_pkg::CAGEN_ST_RUN && intr_take) begin
      vector_r <= take_vector;
    end
  end

  // Working stack pointer decrements per push
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      sp_r <= cagen_pkg::SP_RESET;
    end else if (state_r == cagen_pkg::CAGEN_ST_RUN) begin
      sp_r <= i_stack_pointer;
    end else if (state_r == cagen_pkg::CAGEN_ST_PUSH) begin
      sp_r <= 16'(sp_r - 16'h0001);
    end
  end

  // Vector bytes gathered high first, one cycle after the registered address goes out
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      newpc_r <= 16'h0000;
    end else if ((state_r == cagen_pkg::CAGEN_ST_VECLO) ||
                 (state_r == cagen_pkg::CAGEN_ST_RVEC && count_r == 3'h1)) begin
      newpc_r[15:8] <= i_rdata;
    end else if ((state_r == cagen_pkg::CAGEN_ST_FREE) ||
                 (state_r == cagen_pkg::CAGEN_ST_RVEC && count_r == 3'h2)) begin
      newpc_r[7:0] <= i_rdata;
    end
  end

  // Flags: mask set after flags are stacked, cleared by idle
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      flags_r <= cagen_pkg::FLAGS_RESET;
    end else if (state_r == cagen_pkg::CAGEN_ST_PUSH && count_r == 3'h4) begin
      flags_r[cagen_pkg::IMASK_BIT] <= 1'b1;
    end else if (state_r == cagen_pkg::CAGEN_ST_RUN && state_nxt == cagen_pkg::CAGEN_ST_IDLE) begin
      flags_r[cagen_pkg::IMASK_BIT] <= 1'b0;
    end
  end

  // Debug enable set by command or by reset into debug; catch after release
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      debug_en_r <= 1'b0;
    end else if (i_debug_enable_set ||
                 (state_r == cagen_pkg::CAGEN_ST_RESET && i_reset_into_debug)) begin
      debug_en_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus address and strobes, registered
  logic [15:0] addr_nxt;
  logic rd_nxt;
  logic wr_nxt;
  always_comb begin
    addr_nxt = 16'h0000;
    rd_nxt = 1'b0;
    wr_nxt = 1'b0;
    case (state_r)
      cagen_pkg::CAGEN_ST_RVEC: begin
        rd_nxt = 1'b1;
        case (count_r)
          3'h0: addr_nxt = cagen_pkg::RESET_VEC_HI;
          3'h1: addr_nxt = cagen_pkg::RESET_VEC_LO;
          3'h2: rd_nxt = 1'b0;
          default: addr_nxt = 16'(newpc_r + {13'h0000, 3'(count_r - 3'h3)});
        endcase
      end
      cagen_pkg::CAGEN_ST_RUN: begin
        addr_nxt = agu_bus.addr;
        rd_nxt = i_operand_fetch && agu_bus.mem_read;
      end
      cagen_pkg::CAGEN_ST_PUSH: begin
        addr_nxt = sp_r;
        wr_nxt = 1'b1;
      end
      cagen_pkg::CAGEN_ST_VECHI: begin
        addr_nxt = vector_r;
        rd_nxt = 1'b1;
      end
      cagen_pkg::CAGEN_ST_VECLO: begin
        addr_nxt = 16'(vector_r + 16'h0001);
        rd_nxt = 1'b1;
      end
      cagen_pkg::CAGEN_ST_FILL: begin
        addr_nxt = 16'(newpc_r + {13'h0000, count_r});
        rd_nxt = 1'b1;
      end
      default: addr_nxt = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_addr <= 16'h0000;
      o_rd <= 1'b0;
      o_wr <= 1'b0;
      o_wdata <= 8'h00;
      o_pointer <= 16'h0000;
      o_pointer_load <= 1'b0;
      o_pc <= 16'h0000;
      o_stack_pointer <= cagen_pkg::SP_RESET;
      o_flags <= cagen_pkg::FLAGS_RESET;
      o_cpu_clock_en <= 1'b1;
      o_osc_run <= 1'b0;
      o_debug_active <= 1'b0;
      o_exec <= 1'b0;
    end else begin
      o_addr <= addr_nxt;
      o_rd <= rd_nxt;
      o_wr <= wr_nxt;
      o_wdata <= push_byte;
      // Pointer increment after operand fetch
      o_pointer <= agu_bus.pointer_inc;
      o_pointer_load <= (state_r == cagen_pkg::CAGEN_ST_RUN) && i_operand_fetch && agu_bus.postinc;
      // New fetch address: branch target or vector
      o_pc <= (state_r == cagen_pkg::CAGEN_ST_RUN) ? agu_bus.addr : newpc_r;
      o_stack_pointer <= sp_r;
      o_flags <= flags_r;
      // Clocks gated in idle and halt
      o_cpu_clock_en <= !(state_nxt == cagen_pkg::CAGEN_ST_IDLE ||
                          state_nxt == cagen_pkg::CAGEN_ST_HALT);
      o_osc_run <= debug_en_r;
      o_debug_active <= state_nxt == cagen_pkg::CAGEN_ST_DEBUG;
      o_exec <= state_nxt == cagen_pkg::CAGEN_ST_RUN;
    end
  end
endmodule

// [verif/cagen_mem_model.sv]
// Partner: byte memory on the far side of the memory bus
`timescale 1ns/1ps
module cagen_mem_model (
  input wire logic i_clock,
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem_r [0:65535]; // Memory image
  logic [7:0] last_r; // Last byte driven
  // Reset vector and two service vectors
  initial begin
    mem_r[16'hFFFE] = 8'h12;
    mem_r[16'hFFFF] = 8'h34;
    mem_r[16'hFF04] = 8'h40;
    mem_r[16'hFF05] = 8'h00;
    mem_r[16'hFF10] = 8'h50;
    mem_r[16'hFF11] = 8'h00;
    last_r = 8'h00;
  end
  // Stacked bytes land in memory
  always @(posedge i_clock) begin
    if (i_wr) begin
      mem_r[i_addr] <= i_wdata;
    end
    if (i_rd) begin
      last_r <= mem_r[i_addr];
    end
  end
  // Released bus shows the inverse so stale data never matches
  assign o_rdata = i_rd ? mem_r[i_addr] : ~last_r;
endmodule

// [verif/cagen_top_properties.sv]
// Checker: timing relations at the ports of the address generator and sequencer
`timescale 1ns/1ps
module cagen_top_properties #(
  parameter int NUM_IRQ = 8 // Interrupt sources
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_boundary,
  input wire logic i_soft_trap_op,
  input wire logic i_idle_op,
  input wire logic i_halt_op,
  input wire logic [NUM_IRQ-1:0] i_irq,
  input wire logic [3:0] i_mode,
  input wire logic [15:0] i_operand,
  input wire logic [15:0] i_pointer,
  input wire logic [15:0] i_pc,
  input wire logic [7:0] i_accumulator,
  input wire logic i_operand_fetch,
  input wire logic [15:0] o_addr,
  input wire logic o_rd,
  input wire logic o_wr,
  input wire logic [7:0] o_wdata,
  input wire logic [15:0] o_pointer,
  input wire logic o_pointer_load,
  input wire logic [7:0] o_flags,
  input wire logic o_cpu_clock_en,
  input wire logic o_exec
);
  ////////////////////////////////////////////////////////////////////////////////
  // One clock domain for every property
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // Plain operand access in run, no exception pending
  wire acc_ok = o_exec && i_operand_fetch && !i_boundary;
  wire evt_none = !i_soft_trap_op && !i_idle_op && !i_halt_op;
  ////////////////////////////////////////////////////////////////////////////////
  rst_values_a: assert property ($fell(i_reset) |-> o_flags == cagen_pkg::FLAGS_RESET && !o_exec && !o_wr)
    else $error("bad state after reset");
  rvec_order_a: assert property (o_rd && o_addr == 16'hFFFE && !o_exec |=> o_rd && o_addr == 16'hFFFF ##1 !o_rd ##1 o_rd [*3])
    else $error("reset vector sequence broken");
  push_order_a: assert property ($rose(o_wr) |-> o_wdata == i_pc[7:0]
    ##1 o_wr && o_wdata == i_pc[15:8] ##1 o_wr && o_wdata == i_pointer[7:0]
    ##1 o_wr && o_wdata == i_accumulator ##1 o_wr)
    else $error("stacking order wrong");
  mask_set_a: assert property ($fell(o_wr) |-> ##[0:1] o_flags[cagen_pkg::IMASK_BIT])
    else $error("mask not set after stacking");
  vec_fetch_a: assert property ($fell(o_wr) |-> o_rd ##1 o_rd && o_addr == $past(o_addr) + 16'h0001 ##1 !o_rd ##1 o_rd [*3])
    else $error("vector fetch sequence broken");
  mask_refuse_a: assert property (o_exec && i_boundary && o_flags[3] && evt_none |-> ##1 !o_wr [*3])
    else $error("masked request was taken");
  trap_taken_a: assert property (o_exec && i_boundary && i_soft_trap_op && !i_idle_op && !i_halt_op |-> ##[1:2] o_wr)
    else $error("soft trap not taken");
  idle_gate_a: assert property (o_exec && i_boundary && i_idle_op && i_irq == '0 && !i_soft_trap_op
    |-> ##[1:3] !o_cpu_clock_en && !o_flags[3])
    else $error("idle did not gate clocks");
  regonly_a: assert property (acc_ok && i_mode == cagen_pkg::CAGEN_REGISTER_ONLY_MODE |=> !o_rd)
    else $error("register-only mode read memory");
  pagezero_a: assert property (acc_ok && i_mode == cagen_pkg::CAGEN_PAGE_ZERO_MODE
    |=> o_addr == {cagen_pkg::PAGE_ZERO_HI, $past(i_operand[7:0])})
    else $error("page-zero address wrong");
  postinc_a: assert property (acc_ok && i_mode == cagen_pkg::CAGEN_POINTER_POSTINC_MODE
    |=> o_pointer_load && o_pointer == $past(i_pointer) + 16'h0001)
    else $error("pointer not incremented");
endmodule

bind cagen_top cagen_top_properties #(.NUM_IRQ(NUM_IRQ)) u_props (.*);

// [verif/cagen_top_tb_top.sv]
// Testbench: modes, reset, interrupt, trap, idle, halt and debug entry
`timescale 1ns/1ps
module cagen_top_tb_top;
  logic i_clock = 1'b0, i_reset = 1'b1, i_reset_done = 1'b0, i_boundary = 1'b0;
  logic i_soft_trap_op = 1'b0, i_idle_op = 1'b0, i_halt_op = 1'b0, i_debug_halt_cmd = 1'b0;
  logic i_debug_enable_set = 1'b0, i_reset_into_debug = 1'b0, i_branch_taken = 1'b0, i_operand_fetch = 1'b0;
  logic [7:0] i_irq = 8'h00, i_accumulator = 8'hA7, i_rdata;
  logic [127:0] i_irq_vec;
  logic [15:0] i_soft_trap_vec = 16'hFF10, i_operand = 16'h0000, i_pointer = 16'h0000;
  logic [15:0] i_pc = 16'h0000, i_stack_pointer = 16'h00FF;
  logic [3:0] i_mode = 4'h0;
  logic [15:0] o_addr, o_pointer, o_pc, o_stack_pointer;
  logic [7:0] o_wdata, o_flags;
  logic o_rd, o_wr, o_pointer_load, o_cpu_clock_en, o_osc_run, o_debug_active, o_exec;
  int failures = 0, num_checks = 0, n;
  ////////////////////////////////////////////////////////////////////////////////
  cagen_top #(.NUM_IRQ(8)) uut (.*);
  cagen_mem_model u_mem (.i_clock(i_clock), .i_addr(o_addr), .i_rd(o_rd), .i_wr(o_wr),
    .i_wdata(o_wdata), .o_rdata(i_rdata));
  // Clock, 40 ns period
  always #20 i_clock = ~i_clock;
  ////////////////////////////////////////////////////////////////////////////////
  task wrap_up();
    if (failures == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bounded wait ran out
  task tmo(input int cnt);
    if (cnt >= 20) begin
      failures++;
      wrap_up();
    end
  endtask
  // One-cycle boundary with its qualifiers
  task strobe(input logic t, input logic idl, input logic hlt);
    @(negedge i_clock);
    {i_boundary, i_soft_trap_op, i_idle_op, i_halt_op} = {1'b1, t, idl, hlt};
    @(negedge i_clock);
    {i_boundary, i_soft_trap_op, i_idle_op, i_halt_op} = 4'h0;
  endtask
  function automatic logic [15:0] exp_addr(input int m);
    logic [15:0] s;
    s = {8'h00, i_operand[7:0]};
    case (m)
      3: return s;
      4: return i_operand;
      5, 6: return i_pointer;
      7, 8: return i_pointer + s;
      9: return i_pointer + i_operand;
      10: return i_stack_pointer + s;
      default: return i_stack_pointer + i_operand;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task do_reset();
    @(negedge i_clock);
    {i_reset, i_reset_done} = 2'h2;
    #1;
    chk({o_wr, o_exec, o_debug_active}, 3'h0);
    repeat (12) @(negedge i_clock);
    chk(o_flags, cagen_pkg::FLAGS_RESET);
    i_reset = 1'b0;
    repeat (3) @(negedge i_clock);
    chk(o_exec, 1'b0);
    i_reset_done = 1'b1;
    for (n = 0; n < 20 && o_exec !== 1'b1; n++) @(negedge i_clock);
    tmo(n);
  endtask
  // Every mode at wrapping bases, then a branch not taken
  task t_modes();
    @(negedge i_clock);
    {i_operand, i_pointer, i_stack_pointer, i_pc} = {16'h12A5, 16'hFFC0, 16'hFFF0, 16'h0010};
    {i_operand_fetch, i_branch_taken} = 2'h3;
    for (int m = 0; m < 12; m++) begin
      i_mode = 4'(m);
      @(negedge i_clock);
      if (m == 0) chk(o_rd, 1'b0);
      if (m == 1) chk(o_pc, 16'hFFB5);
      if (m > 2) chk(o_addr, exp_addr(m));
      if (m == 6 || m == 8) chk({o_pointer_load, o_pointer}, {1'b1, 16'hFFC1});
    end
    {i_mode, i_branch_taken} = {4'h1, 1'b0};
    @(negedge i_clock);
    chk(o_pc, 16'h0010);
    i_operand_fetch = 1'b0;
  endtask
  // Stacking, vector and fill walk of one exception
  task exc_check(input logic [15:0] va, input logic [15:0] tgt, input logic [7:0] fl);
    logic [7:0] d [5];
    d = '{i_pc[7:0], i_pc[15:8], i_pointer[7:0], i_accumulator, fl};
    for (n = 0; n < 20 && o_wr !== 1'b1; n++) @(negedge i_clock);
    tmo(n);
    {i_boundary, i_soft_trap_op} = 2'h0;
    for (int k = 0; k < 5; k++) begin
      chk({o_wr, o_addr, o_wdata}, {1'b1, i_stack_pointer - 16'(k), d[k]});
      @(negedge i_clock);
    end
    chk({o_rd, o_addr}, {1'b1, va});
    chk(o_stack_pointer, i_stack_pointer - 16'h0005);
    @(negedge i_clock);
    chk({o_rd, o_addr}, {1'b1, va + 16'h0001});
    @(negedge i_clock);
    chk(o_rd, 1'b0);
    for (int k = 0; k < 3; k++) begin
      @(negedge i_clock);
      chk({o_rd, o_addr}, {1'b1, tgt + 16'(k)});
    end
    chk(o_flags[cagen_pkg::IMASK_BIT], 1'b1);
    for (n = 0; n < 20 && o_exec !== 1'b1; n++) @(negedge i_clock);
    tmo(n);
  endtask
  // Idle, then two sources wake it; bit 2 outranks bit 5
  task t_irq();
    @(negedge i_clock);
    {i_pc, i_pointer} = {16'h2468, 16'hC35A};
    strobe(1'b0, 1'b1, 1'b0);
    for (n = 0; n < 20 && o_cpu_clock_en !== 1'b0; n++) @(negedge i_clock);
    tmo(n);
    // Flags output trails the cleared mask by one cycle
    @(negedge i_clock);
    chk(o_flags[cagen_pkg::IMASK_BIT], 1'b0);
    {i_irq, i_boundary} = {8'h24, 1'b1};
    exc_check(16'hFF04, 16'h4000, 8'h60);
  endtask
  // Masked source refused, soft trap still taken
  task t_trap();
    strobe(1'b0, 1'b0, 1'b0);
    repeat (3) @(negedge i_clock);
    chk(o_wr, 1'b0);
    {i_boundary, i_soft_trap_op} = 2'h3;
    exc_check(16'hFF10, 16'h5000, 8'h68);
    i_irq = 8'h00;
  endtask
  // Debug enable, deep halt, debug-halt command, then reset out of it
  task t_debug();
    @(negedge i_clock);
    i_debug_enable_set = 1'b1;
    @(negedge i_clock);
    i_debug_enable_set = 1'b0;
    strobe(1'b0, 1'b0, 1'b1);
    for (n = 0; n < 20 && o_cpu_clock_en !== 1'b0; n++) @(negedge i_clock);
    tmo(n);
    chk(o_osc_run, 1'b1);
    i_debug_halt_cmd = 1'b1;
    @(negedge i_clock);
    i_debug_halt_cmd = 1'b0;
    for (n = 0; n < 20 && o_debug_active !== 1'b1; n++) @(negedge i_clock);
    tmo(n);
    chk(o_cpu_clock_en, 1'b1);
    i_reset_into_debug = 1'b1;
    do_reset();
    chk(o_osc_run, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    for (int k = 0; k < 8; k++) begin
      i_irq_vec[16*k+:16] = 16'hFF00 + 16'(2 * k);
    end
    do_reset();
    t_modes();
    t_irq();
    t_trap();
    t_debug();
    wrap_up();
  end
  // Hang guard
  initial begin
    #400000;
    failures++;
    wrap_up();
  end
endmodule
